/* logic/sss_top.sv */
// scan start sequencer with axi4-lite registers and tick sequencer
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "sss_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// (RULE1) gateway pulses start one cycle per launch register write
// (RULE2) first edge after start increments the scan serial number
// (RULE3) same edge snapshots all configuration bytes for other modules
// (RULE4) start loads hold-off and round-trip counters, arms sync latch if asked
// (RULE5) nonzero hold-off load drops both run enables next edge
// (RULE6) hold-off counts down each cycle; enables stay low until zero
// (RULE7) receiver run rises when idle and sync satisfied after hold-off
// (RULE8) receiver run stays high until the next start pulse
// (RULE9) round-trip countdown after receiver run; at zero raise acquisition run
// (RULE10) inverted receiver run holds sequencers; all proceed together after
// (RULE11) sequencer emits state, cycle, integration, scan-begin ticks and time
// (RULE12) stage one ticks every state period cycles
// (RULE13) stage two ticks every state period times active switch count
// (RULE14) stage three ticks every state period times count times multiple
// (RULE15) delay registers keep cascaded tick outputs aligned
// (RULE16) metronomes reload while load high, count after it falls
// (RULE17) first counter decrements on first edge after load falls
// (RULE18) scan-begin pulse one cycle, second edge after load seen low
// (RULE19) parent holds load high from start, releases when receiver run rises
// (RULE20) elapsed counter cleared on scan-begin edge, zero during pulse
// (RULE21) phase outputs step through configured sequence on cycle ticks
// (RULE22) diode outputs sequence on integration ticks with a stability flag
// (RULE23) hold-off lasts a few cycles before idle is checked
// (RULE24) hold-off, round trip and widths are configurable
module sss_top #(
   parameter int HOLD_MIN = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pps_tick,
   input wire logic dispatch_idle,
   output logic run_rx,
   output logic run_acq,
   output logic [15:0] scan_serial_number,
   output logic [31:0] scan_cfg0,
   output logic [31:0] scan_cfg1,
   output logic state_tick,
   output logic cycle_tick,
   output logic integ_tick,
   output logic start_tick,
   output logic [31:0] elapsed_time,
   output logic [7:0] phase_ctrl,
   output logic [1:0] diode_ctrl,
   output logic diode_stable
);
   import sss_pkg::*;

   // hold-off counter is eight bits wide, so the floor must fit it
   if (HOLD_MIN < 1 || HOLD_MIN > 255)
   begin : g_bad_hold_min
      $error("HOLD_MIN out of range");
   end

   sss_state_s r;
   sss_state_s next_r;
   logic wr_fire;
   logic rd_fire;
   logic [11:0] raddr;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic load;
   logic [2:0] nsel;
   logic [15:0] state_len;
   logic [7:0] nactive;
   logic [7:0] integ_len;
   logic [7:0] hold_val;
   logic m2_step;
   logic m3_step;

   assign s_axi_awready = !r.aw_got && !r.bvalid;
   assign s_axi_wready = !r.w_got && !r.bvalid;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign run_rx = r.run_rx;
   assign run_acq = r.run_acq;
   assign scan_serial_number = r.serial;
   assign scan_cfg0 = r.snap0;
   assign scan_cfg1 = r.snap1;
   assign state_tick = r.t1_d2;
   assign cycle_tick = r.t2_d1;
   assign integ_tick = r.t3;
   assign start_tick = r.start_tick;
   assign elapsed_time = r.elapsed;
   assign phase_ctrl = r.phase;
   assign diode_ctrl = r.diode;
   assign diode_stable = r.stable;

   // (RULE10) sequencers are held while receiver run is low
   assign load = !r.run_rx;
   assign state_len = r.snap0[`SSS_CFG0_STATE_LSB +: 16];
   assign integ_len = r.snap0[`SSS_CFG0_INTEG_LSB +: 8];
   assign nsel = r.snap0[`SSS_CFG0_NSEL_LSB +: 3];
   // (RULE13) active switch count chosen by a mux on the select field
   assign nactive = (nsel == 3'h0) ? 8'h01 : {5'h00, nsel};
   // (RULE24) hold-off never below the minimum so idle has time to drop
   assign hold_val = (r.dly[`SSS_DELAY_HOLD_LSB +: 8] < 8'(HOLD_MIN)) ? 8'(HOLD_MIN)
      : r.dly[`SSS_DELAY_HOLD_LSB +: 8];
   assign m2_step = r.t1;
   assign m3_step = r.t2;

   always_comb
   begin
      next_r = r;
      wr_fire = (r.aw_got || s_axi_awvalid) && (r.w_got || s_axi_wvalid) && !r.bvalid;
      rd_fire = s_axi_arvalid && !r.rvalid;
      raddr = s_axi_araddr;
      wmask = {{8{next_r.w_strb[3]}}, {8{next_r.w_strb[2]}},
         {8{next_r.w_strb[1]}}, {8{next_r.w_strb[0]}}};
      wval = 32'h00000000;
      next_r.start = 1'b0;
      ////////////////////////////////////////////////////////////////////////
      // axi4-lite slave: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_r.aw_got = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_r.w_got = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      wmask = {{8{next_r.w_strb[3]}}, {8{next_r.w_strb[2]}},
         {8{next_r.w_strb[1]}}, {8{next_r.w_strb[0]}}};
      if (next_r.aw_got && next_r.w_got && wr_fire)
      begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = SSS_OKAY;
         case (next_r.aw_addr)
            `SSS_OFF_LAUNCH:
            begin
               // (RULE1) one-cycle start pulse per launch write
               next_r.start = 1'b1;
               next_r.sync_req = next_r.w_data[`SSS_LAUNCH_SYNC_BIT];
            end
            `SSS_OFF_CFG0:
            begin
               next_r.cfg0 = (r.cfg0 & ~wmask) | (next_r.w_data & wmask);
            end
            `SSS_OFF_CFG1:
            begin
               next_r.cfg1 = (r.cfg1 & ~wmask) | (next_r.w_data & wmask);
            end
            `SSS_OFF_DELAY:
            begin
               next_r.dly = (r.dly & ~wmask) | (next_r.w_data & wmask);
            end
            `SSS_OFF_STATUS, `SSS_OFF_SERIAL, `SSS_OFF_TIME:
            begin
               next_r.bresp = SSS_OKAY;
            end
            default:
            begin
               next_r.bresp = SSS_SLVERR;
            end
         endcase
      end
      if (r.bvalid && s_axi_bready)
      begin
         next_r.bvalid = 1'b0;
      end
      if (rd_fire)
      begin
         next_r.rvalid = 1'b1;
         next_r.rresp = SSS_OKAY;
         case (raddr)
            `SSS_OFF_LAUNCH: wval = {31'h00000000, r.sync_req};
            `SSS_OFF_CFG0: wval = r.cfg0;
            `SSS_OFF_CFG1: wval = r.cfg1;
            `SSS_OFF_STATUS: wval = {27'h0000000, r.stable, r.idle_sync[1],
               r.sync_seen, r.run_acq, r.run_rx};
            `SSS_OFF_SERIAL: wval = {16'h0000, r.serial};
            `SSS_OFF_TIME: wval = r.elapsed;
            `SSS_OFF_DELAY: wval = r.dly;
            default:
            begin
               wval = 32'h00000000;
               next_r.rresp = SSS_SLVERR;
            end
         endcase
         next_r.rdata = wval;
      end
      else if (r.rvalid && s_axi_rready)
      begin
         next_r.rvalid = 1'b0;
      end
      ////////////////////////////////////////////////////////////////////////
      // pin synchronisers; only the second stage is read
      next_r.pps_sync = {r.pps_sync[0], pps_tick};
      next_r.pps_last = r.pps_sync[1];
      next_r.idle_sync = {r.idle_sync[0], dispatch_idle};
      ////////////////////////////////////////////////////////////////////////
      // scan initiator
      if (r.hold_cnt != 8'h00)
      begin
         // (RULE6) hold-off decrements every cycle
         next_r.hold_cnt = r.hold_cnt - 8'h01;
      end
      // sync latch: a tick on the same edge as arming is ignored, it is stale
      if (r.sync_armed && r.pps_sync[1] && !r.pps_last)
      begin
         next_r.sync_seen = 1'b1;
      end
      // (RULE7) (RULE23) idle and sync only checked once hold-off is over
      if (r.hold_cnt == 8'h00 && !r.run_rx && r.idle_sync[1] && r.sync_seen)
      begin
         next_r.run_rx = 1'b1;
         next_r.rt_cnt = r.snap_dly[`SSS_DELAY_RT_LSB +: 16];
      end
      // (RULE9) round trip counted only after receiver run rises
      if (r.run_rx && !r.run_acq)
      begin
         if (r.rt_cnt == 16'h0000)
         begin
            next_r.run_acq = 1'b1;
         end
         else
         begin
            next_r.rt_cnt = r.rt_cnt - 16'h0001;
         end
      end
      // start wins over everything above
      if (r.start)
      begin
         // (RULE2) new identifier per request
         next_r.serial = r.serial + 16'h0001;
         // (RULE3) configuration frozen until the next start
         next_r.snap0 = r.cfg0;
         next_r.snap1 = r.cfg1;
         next_r.snap_dly = r.dly;
         // (RULE4) load both countdowns and arm sync
         next_r.hold_cnt = hold_val;
         next_r.rt_cnt = r.dly[`SSS_DELAY_RT_LSB +: 16];
         next_r.sync_armed = r.sync_req;
         next_r.sync_seen = !r.sync_req;
         // (RULE5) (RULE8) both enables dropped until the new scan starts
         next_r.run_rx = 1'b0;
         next_r.run_acq = 1'b0;
      end
      ////////////////////////////////////////////////////////////////////////
      // tick sequencer: three cascaded metronomes
      next_r.t1 = 1'b0;
      next_r.t2 = 1'b0;
      next_r.t3 = 1'b0;
      if (load)
      begin
         // (RULE16) reload intervals on each edge while held
         next_r.m1_cnt = state_len;
         next_r.m2_cnt = nactive;
         next_r.m3_cnt = integ_len;
      end
      else
      begin
         // (RULE12) (RULE17) stage one counts every clock once released
         if (r.m1_cnt <= 16'h0001)
         begin
            next_r.m1_cnt = state_len;
            next_r.t1 = 1'b1;
         end
         else
         begin
            next_r.m1_cnt = r.m1_cnt - 16'h0001;
         end
         // (RULE13) stage two steps on stage one ticks
         if (m2_step)
         begin
            if (r.m2_cnt <= 8'h01)
            begin
               next_r.m2_cnt = nactive;
               next_r.t2 = 1'b1;
            end
            else
            begin
               next_r.m2_cnt = r.m2_cnt - 8'h01;
            end
         end
         // (RULE14) stage three steps on stage two ticks
         if (m3_step)
         begin
            if (r.m3_cnt <= 8'h01)
            begin
               next_r.m3_cnt = integ_len;
               next_r.t3 = 1'b1;
            end
            else
            begin
               next_r.m3_cnt = r.m3_cnt - 8'h01;
            end
         end
      end
      // (RULE15) equalise pipeline delays so the three ticks line up
      next_r.t1_d1 = r.t1;
      next_r.t1_d2 = r.t1_d1;
      next_r.t2_d1 = r.t2;
      // (RULE18) scan-begin two edges after load first seen low
      next_r.load_d = load;
      next_r.sb1 = r.load_d && !load;
      next_r.start_tick = r.sb1;
      // (RULE20) elapsed time cleared with the scan-begin pulse
      if (r.sb1)
      begin
         next_r.elapsed = 32'h00000000;
      end
      else
      begin
         next_r.elapsed = r.elapsed + 32'h00000001;
      end
      ////////////////////////////////////////////////////////////////////////
      // (RULE11) (RULE21) phase outputs walk the sequence byte on cycle ticks
      if (load)
      begin
         next_r.phase_idx = 3'h0;
      end
      else if (r.t2_d1)
      begin
         next_r.phase_idx = r.phase_idx + 3'h1;
         next_r.phase = {7'h00, r.snap1[`SSS_CFG1_SEQ_LSB + r.phase_idx]};
      end
      // (RULE22) diodes follow the diode byte; stable once a period held
      if (load)
      begin
         next_r.diode_left = 6'h00;
      end
      else if (r.t3)
      begin
         if (r.diode_left <= 6'h01)
         begin
            next_r.stable = (r.diode == r.snap1[`SSS_CFG1_DIODE_LSB +: 2]);
            next_r.diode = r.snap1[`SSS_CFG1_DIODE_LSB +: 2];
            next_r.diode_left = r.snap1[`SSS_CFG1_DIODE_LSB + 2 +: 6];
         end
         else
         begin
            next_r.stable = 1'b1;
            next_r.diode_left = r.diode_left - 6'h01;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r <= '0;
         r.cfg0 <= `SSS_CFG0_RESET;
         r.cfg1 <= `SSS_CFG1_RESET;
         r.dly <= `SSS_DELAY_RESET;
         r.snap0 <= `SSS_CFG0_RESET;
         r.snap1 <= `SSS_CFG1_RESET;
         r.snap_dly <= `SSS_DELAY_RESET;
         r.load_d <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end
endmodule : sss_top
`default_nettype wire

/* logic/sss_regs.svh */
// constants for the scan start sequencer
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH
// axi4-lite byte offsets
`define SSS_OFF_LAUNCH 12'h000
`define SSS_OFF_CFG0 12'h004
`define SSS_OFF_CFG1 12'h008
`define SSS_OFF_STATUS 12'h00c
`define SSS_OFF_SERIAL 12'h010
`define SSS_OFF_TIME 12'h014
`define SSS_OFF_DELAY 12'h018
// launch register fields
`define SSS_LAUNCH_SYNC_BIT 0
// cfg0 fields: state_len [15:0], integ_len [23:16], switch select [26:24]
`define SSS_CFG0_STATE_LSB 0
`define SSS_CFG0_INTEG_LSB 16
`define SSS_CFG0_NSEL_LSB 24
// cfg1 fields: phase sequence byte [7:0], diode byte [15:8]
`define SSS_CFG1_SEQ_LSB 0
`define SSS_CFG1_DIODE_LSB 8
// delay register fields: hold-off [7:0], round trip [23:8]
`define SSS_DELAY_HOLD_LSB 0
`define SSS_DELAY_RT_LSB 8
// reset values
`define SSS_CFG0_RESET 32'h01020004
`define SSS_CFG1_RESET 32'h00000000
`define SSS_DELAY_RESET 32'h00001004
// status bits
`define SSS_ST_RUN_RX 0
`define SSS_ST_RUN_ACQ 1
`define SSS_ST_SYNC_SEEN 2
`define SSS_ST_IDLE 3
`define SSS_ST_STABLE 4
`endif

/* logic/sss_pkg.sv */
// types for the scan start sequencer
`default_nettype none
package sss_pkg;
   typedef enum logic [1:0] {
      SSS_OKAY = 2'b00,
      SSS_SLVERR = 2'b10
   } sss_resp_e;
   typedef struct packed {
      logic aw_got;
      logic [11:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic start;
      logic sync_req;
      logic [31:0] cfg0;
      logic [31:0] cfg1;
      logic [31:0] dly;
      logic [31:0] snap0;
      logic [31:0] snap1;
      logic [31:0] snap_dly;
      logic [15:0] serial;
      logic [7:0] hold_cnt;
      logic [15:0] rt_cnt;
      logic sync_armed;
      logic sync_seen;
      logic run_rx;
      logic run_acq;
      logic [1:0] pps_sync;
      logic pps_last;
      logic [1:0] idle_sync;
      logic [15:0] m1_cnt;
      logic [7:0] m2_cnt;
      logic [7:0] m3_cnt;
      logic t1;
      logic t2;
      logic t3;
      logic t1_d1;
      logic t1_d2;
      logic t2_d1;
      logic load_d;
      logic sb1;
      logic start_tick;
      logic [31:0] elapsed;
      logic [7:0] phase;
      logic [2:0] phase_idx;
      logic [1:0] diode;
      logic [5:0] diode_left;
      logic stable;
   } sss_state_s;
endpackage : sss_pkg
`default_nettype wire

/* bench/sss_chk.sv */
// concurrent checks on the scan start sequencer ports
`timescale 1ns/100ps
`default_nettype none
module sss_chk #(
   parameter int HOLD_MIN = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run_rx,
   input wire logic run_acq,
   input wire logic [15:0] scan_serial_number,
   input wire logic [31:0] scan_cfg0,
   input wire logic [31:0] scan_cfg1,
   input wire logic state_tick,
   input wire logic cycle_tick,
   input wire logic integ_tick,
   input wire logic start_tick,
   input wire logic [31:0] elapsed_time
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // four idle cycles match the default hold-off floor
   sequence s_halted;
      (!run_rx && !run_acq) [*4];
   endsequence
   sequence s_begin;
      !start_tick ##2 start_tick ##1 !start_tick;
   endsequence
   property p_serial_step;
      $changed(scan_serial_number) |-> scan_serial_number == $past(scan_serial_number) + 16'h1;
   endproperty
   property p_snap_hold;
      !$changed(scan_serial_number) |-> $stable(scan_cfg0) && $stable(scan_cfg1);
   endproperty
   property p_halt;
      $changed(scan_serial_number) |-> s_halted;
   endproperty
   property p_rx_hold;
      $fell(run_rx) |-> $changed(scan_serial_number);
   endproperty
   property p_acq_delay;
      $rose(run_rx) |-> ##[16:18] $rose(run_acq);
   endproperty
   property p_acq_needs_rx;
      run_acq |-> run_rx;
   endproperty
   property p_begin;
      $rose(run_rx) |-> s_begin;
   endproperty
   property p_elapsed;
      start_tick |-> elapsed_time == 32'h0 ##1 elapsed_time == 32'h1;
   endproperty
   property p_align;
      (integ_tick || cycle_tick) |-> state_tick && (cycle_tick || !integ_tick);
   endproperty
   a_serial_step: assert property (p_serial_step)
      else $error("serial number step wrong");
   a_snap_hold: assert property (p_snap_hold)
      else $error("snapshot moved without a start");
   a_halt: assert property (p_halt)
      else $error("run enables not held low after start");
   a_rx_hold: assert property (p_rx_hold)
      else $error("receiver run dropped without a start");
   a_acq_delay: assert property (p_acq_delay)
      else $error("acquisition run not one round trip later");
   a_acq_needs_rx: assert property (p_acq_needs_rx)
      else $error("acquisition run without receiver run");
   a_begin: assert property (p_begin)
      else $error("scan begin pulse misplaced");
   a_elapsed: assert property (p_elapsed)
      else $error("elapsed time not cleared at scan begin");
   a_align: assert property (p_align)
      else $error("cascaded ticks not aligned");
endmodule : sss_chk
bind sss_top sss_chk #(.HOLD_MIN(HOLD_MIN)) i_chk (.aclk(aclk), .aresetn(aresetn),
   .run_rx(run_rx), .run_acq(run_acq), .scan_serial_number(scan_serial_number),
   .scan_cfg0(scan_cfg0), .scan_cfg1(scan_cfg1), .state_tick(state_tick),
   .cycle_tick(cycle_tick), .integ_tick(integ_tick), .start_tick(start_tick),
   .elapsed_time(elapsed_time));
`default_nettype wire

/* bench/sss_far_model.sv */
// far side model: dispatcher idle level and one-second tick source
`timescale 1ns/100ps
`default_nettype none
module sss_far_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run_rx,
   input wire logic integ_tick,
   input wire logic [7:0] busy_len,
   input wire logic pps_en,
   output logic dispatch_idle,
   output logic pps_tick
);
   logic prev_rx;
   logic [7:0] busy;
   logic [5:0] pps_cnt;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_rx <= 1'b0;
         busy <= 8'h0;
         pps_cnt <= 6'h0;
      end
      else
      begin
         prev_rx <= run_rx;
         pps_cnt <= pps_cnt + 6'h1;
         if ((prev_rx && !run_rx) || integ_tick)
            busy <= busy_len;
         else if (busy != 8'h0)
            busy <= busy - 8'h1;
      end
   end
   // tick is a scaled second, several cycles wide
   assign dispatch_idle = (busy == 8'h0);
   assign pps_tick = pps_en && (pps_cnt < 6'h4);
endmodule : sss_far_model
`default_nettype wire

/* bench/scan_start_sequencer_tb_top.sv */
// self-checking bench for the scan start sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sss_regs.svh"
module scan_start_sequencer_tb_top;
   import sss_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, pps_en = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, seed = 32'h12e7;
   logic [3:0] wstrb = 4'hf;
   logic [7:0] busy_len = 8'h0;
   logic awready, wready, bvalid, arready, rvalid, pps_tick, dispatch_idle, run_rx, run_acq;
   logic state_tick, cycle_tick, integ_tick, start_tick, diode_stable;
   logic [1:0] bresp, rresp, diode_ctrl;
   logic [31:0] rdata, scan_cfg0, scan_cfg1, elapsed_time;
   logic [15:0] scan_serial_number, exp_sn = 16'h0, sn_prev = 16'h0;
   logic [7:0] phase_ctrl;
   logic [31:0] cur_c1 = 32'h0;
   logic [1:0] prev_dd = 2'h0;
   logic [2:0] ph_idx = 3'h0;
   logic ph_due = 1'b0, dd_due = 1'b0, exp_ph = 1'b0;
   int n_int = 0;
   logic [33:0] rd_q[$];
   logic [1:0] b_q[$];
   logic [15:0] sn_q[$];
   int n_fail = 0, samples_checked = 0, cyc = 0;
   int per[3], last[3];
   wire [2:0] tk = {integ_tick, cycle_tick, state_tick};
   sss_top #(.HOLD_MIN(4)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pps_tick(pps_tick),
      .dispatch_idle(dispatch_idle), .run_rx(run_rx), .run_acq(run_acq),
      .scan_serial_number(scan_serial_number), .scan_cfg0(scan_cfg0), .scan_cfg1(scan_cfg1),
      .state_tick(state_tick), .cycle_tick(cycle_tick), .integ_tick(integ_tick),
      .start_tick(start_tick), .elapsed_time(elapsed_time), .phase_ctrl(phase_ctrl),
      .diode_ctrl(diode_ctrl), .diode_stable(diode_stable));
   sss_far_model i_far (.aclk(aclk), .aresetn(aresetn), .run_rx(run_rx),
      .integ_tick(integ_tick), .busy_len(busy_len), .pps_en(pps_en),
      .dispatch_idle(dispatch_idle), .pps_tick(pps_tick));
   always #25 aclk = ~aclk;
   ////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic print_verdict();
      if (n_fail == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string name, input logic [33:0] e, input logic [33:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   // response is noted now, compared when it appears
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      b_q.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
      rd_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd
   task automatic scan(input logic sync, input logic [7:0] busy);
      logic [31:0] c0, c1;
      logic [15:0] sl, na;
      int n;
      seed = xs(seed);
      sl = 16'h2 + 16'(seed[1:0]);
      na = (seed[3:2] == 2'h0) ? 16'h1 : 16'(seed[3:2]);
      c0 = {6'h0, seed[3:2], 8'h02, sl};
      seed = xs(seed);
      c1 = seed;
      axi_wr(`SSS_OFF_CFG0, c0, SSS_OKAY);
      axi_wr(`SSS_OFF_CFG1, c1, SSS_OKAY);
      busy_len <= busy;
      pps_en <= ~sync;
      exp_sn = exp_sn + 16'h1;
      sn_q.push_back(exp_sn);
      axi_wr(`SSS_OFF_LAUNCH, {31'h0, sync}, SSS_OKAY);
      axi_wr(`SSS_OFF_CFG0, ~c0, SSS_OKAY);
      repeat (20) @(posedge aclk);
      chk("rx waits", 34'h0, 34'(run_rx));
      pps_en <= 1'b1;
      n = 0;
      while (!run_rx && n < 300)
      begin
         @(posedge aclk);
         n++;
      end
      chk("rx rose", 34'h1, 34'(run_rx));
      chk("cfg0 snap", 34'(c0), 34'(scan_cfg0));
      chk("cfg1 snap", 34'(c1), 34'(scan_cfg1));
      per[0] = int'(sl);
      per[1] = int'(sl * na);
      per[2] = per[1] * 2;
      prev_dd = cur_c1[`SSS_CFG1_DIODE_LSB +: 2];
      cur_c1 = c1;
      repeat (300) @(posedge aclk);
      axi_rd(`SSS_OFF_SERIAL, {SSS_OKAY, 16'h0, exp_sn});
      axi_rd(`SSS_OFF_LAUNCH, {SSS_OKAY, 31'h0, sync});
   endtask : scan
   ////////////////////////////////////////
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         print_verdict();
      end
   end
   always @(posedge aclk)
   begin
      if (rvalid && rready)
         chk("read", rd_q.pop_front(), {rresp, rdata});
      if (bvalid && bready)
         chk("bresp", {32'h0, b_q.pop_front()}, {32'h0, bresp});
      if (aresetn && scan_serial_number !== sn_prev)
      begin
         chk("serial", 34'(sn_q.pop_front()), 34'(scan_serial_number));
         sn_prev = scan_serial_number;
      end
      // outputs move on the edge after a tick, and only while receiver run is high
      if (ph_due)
         chk("phase", {33'h0, exp_ph}, 34'(phase_ctrl));
      if (dd_due)
         chk("diode", 34'(cur_c1[`SSS_CFG1_DIODE_LSB +: 2]), 34'(diode_ctrl));
      if (dd_due && n_int == 1)
         chk("stable", 34'(prev_dd == cur_c1[`SSS_CFG1_DIODE_LSB +: 2]), 34'(diode_stable));
      ph_due = cycle_tick && run_rx;
      dd_due = integ_tick && run_rx;
      if (start_tick)
      begin
         ph_idx = 3'h0;
         n_int = 0;
      end
      if (ph_due)
      begin
         exp_ph = cur_c1[`SSS_CFG1_SEQ_LSB + ph_idx];
         ph_idx = ph_idx + 3'h1;
      end
      if (dd_due)
         n_int++;
      for (int k = 0; k < 3; k++)
         if (start_tick)
            last[k] = 0;
         else if (tk[k])
         begin
            if (last[k] != 0)
               chk("tick period", 34'(per[k]), 34'(cyc - last[k]));
            last[k] = cyc;
         end
   end
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(`SSS_OFF_CFG0, {SSS_OKAY, `SSS_CFG0_RESET});
      axi_rd(`SSS_OFF_CFG1, {SSS_OKAY, `SSS_CFG1_RESET});
      axi_rd(`SSS_OFF_DELAY, {SSS_OKAY, `SSS_DELAY_RESET});
      axi_rd(12'h040, {SSS_SLVERR, 32'h0});
      axi_wr(12'h040, 32'h5a5a5a5a, SSS_SLVERR);
      scan(1'b1, 8'h0);
      scan(1'b0, 8'h28);
      print_verdict();
   end
endmodule : scan_start_sequencer_tb_top
`default_nettype wire
